// *** amxs_map.svh ***
// register offsets, field positions and timing counts for the mux sequencer
`ifndef AMXS_MAP_SVH
`define AMXS_MAP_SVH

`define AMXS_ADDR_W            16
`define AMXS_EQU_ADDR          16'h2000
`define AMXS_SEQ_ADDR          16'h2002
`define AMXS_ALT_ADDR          16'h2005
`define AMXS_EQU_MSB           7
`define AMXS_EQU_LSB           5
`define AMXS_DIV_MSB           7
`define AMXS_DIV_LSB           6
`define AMXS_CHOP_MSB          5
`define AMXS_CHOP_LSB          4
`define AMXS_ALT_BIT           2
`define AMXS_RES_BIT           4
`define AMXS_REG_RESET         8'h00
`define AMXS_CONV_CYC_21       2'h2
`define AMXS_CONV_CYC_22       2'h3
`define AMXS_SLOW_HZ           32768
`define AMXS_SYS_HZ            20000000
`define AMXS_SLOW_DIV          (`AMXS_SYS_HZ / `AMXS_SLOW_HZ)

`endif

// *** amxs_pkg.sv ***
// types for the mux sequencer
package amxs_pkg;
    typedef enum logic [1:0] {
        AMXS_CHOP_NORMAL = 2'b00,
        AMXS_CHOP_INVERT = 2'b01,
        AMXS_CHOP_TOGGLE = 2'b10,
        AMXS_CHOP_TOG2   = 2'b11
    } amxs_chop_t;

    typedef enum logic [2:0] {
        AMXS_SRC_IA   = 3'h0,
        AMXS_SRC_VA   = 3'h1,
        AMXS_SRC_IB   = 3'h2,
        AMXS_SRC_VB   = 3'h3,
        AMXS_SRC_IC   = 3'h4,
        AMXS_SRC_VC   = 3'h5,
        AMXS_SRC_TEMP = 3'h6,
        AMXS_SRC_AUX  = 3'h7
    } amxs_src_t;

    typedef enum logic [1:0] {
        AMXS_ST_IDLE = 2'b00,
        AMXS_ST_CONV = 2'b01,
        AMXS_ST_NEXT = 2'b10
    } amxs_state_t;
endpackage

// *** amxs_slow_tick.sv ***
// divider producing the 32768 Hz enable pulse from the system clock
`timescale 1ns/1ps
`default_nettype none
module amxs_slow_tick
#(
    parameter int DIV = 610
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // enable out
    output logic      tick
);
    logic [15:0] cnt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt == 16'(DIV - 1))
        begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // amxs_slow_tick
`default_nettype wire

// *** amxs_sequencer.sv ***
// multiplexer sequencer for the metering front end
`include "amxs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module amxs_sequencer
    import amxs_pkg::*;
#(
    parameter int RES_W = 22
)
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // i/o ram write and read port
    input  wire logic                      cfg_wr,
    input  wire logic [`AMXS_ADDR_W-1:0]   cfg_addr,
    input  wire logic [7:0]                cfg_wdata,
    output logic      [7:0]                cfg_rdata,
    // converter and filter
    input  wire logic [RES_W-1:0]          fir_result,
    output logic      [2:0]                mux_select,
    output logic                           conv_start,
    output logic                           resolution_select,
    output logic                           chop_polarity,
    // engine data memory
    output logic                           dmem_wr,
    output logic      [2:0]                dmem_addr,
    output logic      [RES_W-1:0]          dmem_wdata,
    // engine and processor
    output logic                           ce_start,
    output logic                           ce_busy_irq,
    output logic      [2:0]                meter_formula_select,
    // comparator
    input  wire logic                      aux_monitor_input,
    output logic                           aux_above_midrail
);
    logic [7:0]  reg_equ;
    logic [7:0]  reg_seq;
    logic [7:0]  reg_alt;
    logic        tick;
    logic        alt_prev;
    logic        alt_pending;
    logic        alt_active;
    logic [2:0]  mux_state;
    logic [1:0]  conv_cnt;
    logic        cur_chop;
    amxs_chop_t  chop_mode;
    amxs_state_t st;
    logic [2:0]  last_state;
    logic [2:0]  next_last;
    logic        enter_q;
    logic [1:0]  conv_len;
    logic        alt_edge;
    logic [2:0]  aux_sync;

    function automatic logic [2:0] states_last(input logic [1:0] div);
        unique case (div)
            2'b00: states_last = 3'h1;
            2'b01: states_last = 3'h2;
            2'b10: states_last = 3'h3;
            2'b11: states_last = 3'h5;
        endcase
    endfunction

    function automatic logic [2:0] src_of(input logic alt, input logic [2:0] s);
        if (alt)
        begin
            unique case (s)
                3'h0:    src_of = AMXS_SRC_TEMP;
                3'h1:    src_of = AMXS_SRC_VA;
                3'h2:    src_of = AMXS_SRC_AUX;
                3'h3:    src_of = AMXS_SRC_VB;
                3'h4:    src_of = AMXS_SRC_IC;
                default: src_of = AMXS_SRC_VC;
            endcase
        end
        else
        begin
            src_of = s;
        end
    endfunction

    amxs_slow_tick #(.DIV(`AMXS_SLOW_DIV)) u_tick
    (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    assign next_last  = states_last(reg_seq[`AMXS_DIV_MSB:`AMXS_DIV_LSB]);
    assign conv_len   = reg_alt[`AMXS_RES_BIT] ? `AMXS_CONV_CYC_22 : `AMXS_CONV_CYC_21;
    assign alt_edge   = reg_alt[`AMXS_ALT_BIT] && !alt_prev;

    // i/o ram registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_equ <= `AMXS_REG_RESET;
            reg_seq <= `AMXS_REG_RESET;
            reg_alt <= `AMXS_REG_RESET;
        end
        else if (cfg_wr)
        begin
            if (cfg_addr == `AMXS_EQU_ADDR)
                reg_equ <= cfg_wdata;
            if (cfg_addr == `AMXS_SEQ_ADDR)
                reg_seq <= cfg_wdata;
            if (cfg_addr == `AMXS_ALT_ADDR)
                reg_alt <= cfg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_rdata <= 8'h00;
        else if (cfg_addr == `AMXS_EQU_ADDR)
            cfg_rdata <= reg_equ;
        else if (cfg_addr == `AMXS_SEQ_ADDR)
            cfg_rdata <= reg_seq;
        else if (cfg_addr == `AMXS_ALT_ADDR)
            cfg_rdata <= reg_alt;
        else
            cfg_rdata <= 8'h00;
    end

    // request edge caught on system clock so one-cycle pulses are seen
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alt_prev    <= 1'b0;
            alt_pending <= 1'b0;
        end
        else
        begin
            alt_prev <= reg_alt[`AMXS_ALT_BIT];
            if (alt_edge)
                alt_pending <= 1'b1;
            else if (tick && st != AMXS_ST_CONV && (st == AMXS_ST_IDLE
                     || mux_state == last_state))
                alt_pending <= 1'b0;
        end
    end

    // sequencer proper
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st         <= AMXS_ST_IDLE;
            mux_state  <= 3'h0;
            conv_cnt   <= 2'h0;
            alt_active <= 1'b0;
            cur_chop   <= 1'b0;
            chop_mode  <= AMXS_CHOP_NORMAL;
            last_state <= 3'h1;
        end
        else if (tick)
        begin
            unique case (st)
                AMXS_ST_IDLE, AMXS_ST_NEXT:
                begin
                    if (st == AMXS_ST_IDLE || mux_state == last_state)
                    begin
                        mux_state  <= 3'h0;
                        // state count only changes at a boundary
                        last_state <= next_last;
                        alt_active <= alt_pending && !alt_edge;
                        chop_mode  <= amxs_chop_t'(reg_seq[`AMXS_CHOP_MSB:`AMXS_CHOP_LSB]);
                        unique case (amxs_chop_t'(reg_seq[`AMXS_CHOP_MSB:`AMXS_CHOP_LSB]))
                            AMXS_CHOP_NORMAL: cur_chop <= 1'b0;
                            AMXS_CHOP_INVERT: cur_chop <= 1'b1;
                            AMXS_CHOP_TOGGLE,
                            AMXS_CHOP_TOG2:   cur_chop <= ~cur_chop;
                        endcase
                    end
                    else
                        mux_state <= mux_state + 3'h1;
                    conv_cnt <= 2'h1;
                    st       <= AMXS_ST_CONV;
                end
                AMXS_ST_CONV:
                begin
                    if (conv_cnt == conv_len)
                        st <= AMXS_ST_NEXT;
                    else
                        conv_cnt <= conv_cnt + 2'h1;
                end
                default: st <= AMXS_ST_IDLE;
            endcase
        end
    end

    // datapath outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_select           <= 3'h0;
            conv_start           <= 1'b0;
            resolution_select    <= 1'b0;
            chop_polarity        <= 1'b0;
            dmem_wr              <= 1'b0;
            dmem_addr            <= 3'h0;
            dmem_wdata           <= '0;
            ce_start             <= 1'b0;
            ce_busy_irq          <= 1'b0;
            meter_formula_select <= 3'h0;
            enter_q              <= 1'b0;
        end
        else
        begin
            mux_select           <= src_of(alt_active, mux_state);
            resolution_select    <= reg_alt[`AMXS_RES_BIT];
            chop_polarity        <= cur_chop;
            meter_formula_select <= reg_equ[`AMXS_EQU_MSB:`AMXS_EQU_LSB];
            // start one clock after state entry, aligned with mux_select
            enter_q     <= tick && st != AMXS_ST_CONV;
            conv_start  <= enter_q;
            ce_start    <= enter_q && mux_state == 3'h0;
            dmem_wr     <= tick && st == AMXS_ST_CONV && conv_cnt == conv_len;
            dmem_addr   <= src_of(alt_active, mux_state);
            dmem_wdata  <= fir_result;
            ce_busy_irq <= tick && st == AMXS_ST_CONV && conv_cnt == conv_len
                           && mux_state == last_state;
        end
    end

    // aux comparator input, three-stage synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_sync          <= 3'h0;
            aux_above_midrail <= 1'b0;
        end
        else
        begin
            aux_sync <= {aux_sync[1:0], aux_monitor_input};
            if (aux_sync[1] == aux_sync[2])
                aux_above_midrail <= aux_sync[2];
        end
    end

    a_chop_steady: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(chop_polarity) |-> ce_start)
        else $error("chopper changed inside a cycle");

    a_alt_state0: assert property (@(posedge clk) disable iff (!rst_n)
        conv_start && alt_active && mux_state == 3'h0 |-> mux_select == AMXS_SRC_TEMP)
        else $error("alternate state 0 not temperature");

    a_reg_state: assert property (@(posedge clk) disable iff (!rst_n)
        conv_start && !alt_active |-> mux_select == mux_state)
        else $error("regular selection wrong");

    a_conv_len: assert property (@(posedge clk) disable iff (!rst_n)
        conv_start && !reg_alt[`AMXS_RES_BIT] |-> ##1 !dmem_wr [* 8])
        else $error("conversion ended too early");

    a_state_max: assert property (@(posedge clk) disable iff (!rst_n)
        mux_state <= last_state || st == AMXS_ST_NEXT)
        else $error("state beyond cycle length");

    a_pass_start: assert property (@(posedge clk) disable iff (!rst_n)
        ce_start |-> conv_start && mux_select == src_of(alt_active, 3'h0))
        else $error("engine start off state 0");

    a_wr_addr: assert property (@(posedge clk) disable iff (!rst_n)
        dmem_wr |-> dmem_addr <= 3'h7 && !conv_start)
        else $error("bad result write");

    a_chop_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        ce_start && chop_mode == AMXS_CHOP_INVERT |-> chop_polarity)
        else $error("inverted mode not held");
endmodule // amxs_sequencer
`default_nettype wire

// *** amxs_afe_model.sv ***
// converter and filter stand-in driving results into the sequencer
`timescale 1ns/1ps
`default_nettype none
module amxs_afe_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // sequencer side
    input  wire logic        conv_start,
    input  wire logic        dmem_wr,
    output logic      [21:0] fir_result
);
    // fresh result per conversion, spoiled once it has been taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fir_result <= 22'h000000;
        else if (conv_start)
            fir_result <= 22'($urandom);
        else if (dmem_wr)
            fir_result <= ~fir_result;
    end
endmodule // amxs_afe_model
`default_nettype wire

// *** afe_mux_sequencer_bench.sv ***
// self-checking bench for the mux sequencer
`timescale 1ns/1ps
`default_nettype none
module afe_mux_sequencer_bench
    import amxs_pkg::*;
;
    logic        clk = 0, rst_n = 0, cfg_wr = 0, aux = 0;
    logic [15:0] cfg_addr = 16'h0000;
    logic [7:0]  cfg_wdata = 8'h00, cfg_rdata;
    logic [21:0] fir_result, dmem_wdata;
    logic [2:0]  mux_select, dmem_addr, formula, lsrc;
    logic        conv_start, res_sel, chop, dmem_wr, ce_start, irq, aux_hi;
    logic        prev_chop, chop0;
    int          n_errors = 0, n_checks = 0;
    int          idx, n, ncyc, mode, res, lidx, want_alt = 0, cur_alt = 0;
    bit          sync = 0, lv = 0;
    longint      lt;
    localparam amxs_src_t TBL [2][6] = '{
        '{AMXS_SRC_IA, AMXS_SRC_VA, AMXS_SRC_IB, AMXS_SRC_VB, AMXS_SRC_IC, AMXS_SRC_VC},
        '{AMXS_SRC_TEMP, AMXS_SRC_VA, AMXS_SRC_AUX, AMXS_SRC_VB, AMXS_SRC_IC, AMXS_SRC_VC}};

    always #25 clk = ~clk;

    amxs_sequencer i_amxs_sequencer (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .fir_result(fir_result), .mux_select(mux_select), .conv_start(conv_start),
        .resolution_select(res_sel), .chop_polarity(chop), .dmem_wr(dmem_wr),
        .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .ce_start(ce_start),
        .ce_busy_irq(irq), .meter_formula_select(formula),
        .aux_monitor_input(aux), .aux_above_midrail(aux_hi));

    amxs_afe_model i_amxs_afe_model (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
        .dmem_wr(dmem_wr), .fir_result(fir_result));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1;
        @(negedge clk);
        cfg_wr = 0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        cfg_addr = a;
        @(negedge clk);
        check(cfg_rdata, exp);
    endtask

    // reconfigure just after a conversion start, well away from a boundary
    task automatic cfg(input int d, input int c, input int r);
        logic [7:0] e;
        e = {3'($urandom), 5'h00};
        @(posedge conv_start);
        wr(16'h2000, e);
        wr(16'h2002, {2'(d), 2'(c), 4'h0});
        wr(16'h2005, {3'h0, 1'(r), 4'h0});
        wr(16'h2003, 8'hFF);
        rd(16'h2000, e);
        rd(16'h2002, {2'(d), 2'(c), 4'h0});
        rd(16'h2003, 8'h00);
        check(formula, e[7:5]);
        check(res_sel, r);
        mode = c;
        res = r;
        n = (d == 3) ? 6 : d + 2;
        sync = 0;
        lv = 0;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge ce_start);
        @(negedge clk);
    endtask

    always @(negedge clk)
    begin
        if (rst_n && conv_start)
        begin
            if (!sync && ce_start)
            begin
                sync = 1;
                idx = 0;
                ncyc = 0;
            end
            if (sync)
            begin
                if (idx == 0)
                begin
                    cur_alt = want_alt;
                    want_alt = 0;
                    if (mode < 2)
                        check(chop, mode);
                    else if (ncyc > 0)
                        check(chop, !prev_chop);
                    prev_chop = chop;
                    chop0 = chop;
                    ncyc++;
                end
                check(ce_start, idx == 0);
                check(mux_select, TBL[cur_alt][idx]);
                check(chop, chop0);
                lsrc = TBL[cur_alt][idx];
                lidx = idx;
                lt = $time;
                idx = (idx + 1) % n;
            end
            lv = sync;
        end
        if (rst_n && dmem_wr && lv)
        begin
            check(dmem_addr, lsrc);
            check(dmem_wdata, fir_result);
            check(irq, lidx == n - 1);
            check(int'(($time - lt) / 50), (res ? 3 : 2) * 610 - 1);
        end
    end

    initial
    begin
        repeat (98000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end

    initial
    begin
        void'($urandom(58981));
        repeat (10) @(negedge clk);
        rst_n = 1;
        rd(16'h2000, 8'h00);
        rd(16'h2002, 8'h00);
        rd(16'h2005, 8'h00);
        cfg(3, 2, 0);
        cycles(1);
        // two-clock request pulse, cleared at once
        @(posedge conv_start);
        want_alt = 1;
        wr(16'h2005, 8'h04);
        wr(16'h2005, 8'h00);
        cycles(3);
        for (int d = 0; d < 3; d++)
        begin
            cfg(d, (d == 2) ? 3 : d, d & 1);
            cycles(2);
        end
        aux = 1'($urandom);
        repeat (40) @(negedge clk);
        check(aux_hi, aux);
        report_and_stop;
    end
endmodule // afe_mux_sequencer_bench
`default_nettype wire
